// *** rtl/fault_filter_pkg.sv ***
// package for the supply fault filter and test path block
// assumes one 50 MHz core clock drives every user of these constants
package fault_filter_pkg;
    // -------------------------------------------------------------
    // timing
    // -------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int FAULT_FILTER_DELAY_NS = 10000;
    localparam int FAULT_FILTER_MIN_CLOCKS = 256;
    localparam int DELAY_FROM_TIME = FAULT_FILTER_DELAY_NS / CLK_PERIOD_NS;
    localparam int FAULT_FILTER_CYCLES = (DELAY_FROM_TIME > FAULT_FILTER_MIN_CLOCKS) ?
        DELAY_FROM_TIME : FAULT_FILTER_MIN_CLOCKS;
    // -------------------------------------------------------------
    // widths and fields
    // -------------------------------------------------------------
    localparam int SAMPLE_WIDTH = 16;
    localparam int REGULATOR_COUNT = 3;
    localparam int SUPPLY_SRC_COUNT = 3;
    localparam int SRC_VDD_OV = 0;
    localparam int SRC_GND_OFF = 1;
    localparam int SRC_VDD_OFF = 2;
    localparam logic [1:0] SRC_MAGNETIC = 2'h0;
    localparam logic [1:0] SRC_ANGLE_TEST = 2'h1;
    localparam logic [1:0] SRC_TEMPERATURE = 2'h2;
    localparam logic [SAMPLE_WIDTH-1:0] SAMPLE_RESET = 16'h0000;
    typedef enum logic [1:0] {PATH_IDLE, PATH_HELD, PATH_ONESHOT} path_state_t;
endpackage

// *** rtl/supply_fault_filter_and_test_path.sv ***
// output path selection for test sources and spike filtering of supply comparators
// assumes comparator levels arrive asynchronously; sample strobes are on ref_clk_i
// Behaviour
// - one shared selector substitutes the angle test or the temperature into the output.
// - held mode keeps the substitute source connected until the mode is ended.
// - automatic mode returns to the magnetic value after exactly one value is read out.
// - a comparator status bit sets only after its fault lasts at least 256 core clocks.
// - the filtered comparator bits are exposed as status outputs for the serial registers.
// - each regulator has its own overvoltage detector that sets its own flag.
// - an external supply overvoltage sets the shared supply fault status bit.
// - a ground to ground test pin difference sets the shared supply fault status bit.
// - the supply disconnect detector, also fired by clock spikes, sets the shared bit.
// - with temperature selected, the temperature goes out in the x value slot.
module supply_fault_filter_and_test_path
    import fault_filter_pkg::*;
#(
    parameter int FILTER_CYCLES = fault_filter_pkg::FAULT_FILTER_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic test_enable_i,
    input wire logic test_auto_i,
    input wire logic temp_select_i,
    input wire logic value_read_i,
    input wire logic [fault_filter_pkg::SAMPLE_WIDTH-1:0] mag_x_i,
    input wire logic [fault_filter_pkg::SAMPLE_WIDTH-1:0] mag_y_i,
    input wire logic [fault_filter_pkg::SAMPLE_WIDTH-1:0] angle_test_x_i,
    input wire logic [fault_filter_pkg::SAMPLE_WIDTH-1:0] angle_test_y_i,
    input wire logic [fault_filter_pkg::SAMPLE_WIDTH-1:0] temp_value_i,
    input wire logic [fault_filter_pkg::REGULATOR_COUNT-1:0] regulator_ov_cmp_i,
    input wire logic vdd_ov_cmp_i,
    input wire logic gnd_off_cmp_i,
    input wire logic vdd_off_cmp_i,
    output logic [fault_filter_pkg::SAMPLE_WIDTH-1:0] out_x_o,
    output logic [fault_filter_pkg::SAMPLE_WIDTH-1:0] out_y_o,
    output logic [1:0] path_source_o,
    output logic [fault_filter_pkg::REGULATOR_COUNT-1:0] regulator_overvoltage_flag_o,
    output logic [fault_filter_pkg::SUPPLY_SRC_COUNT-1:0] supply_source_flag_o,
    output logic supply_fault_status_o
);
    import fault_filter_pkg::*;

    localparam int NCMP = REGULATOR_COUNT + SUPPLY_SRC_COUNT;
    localparam int CW = $clog2(FILTER_CYCLES + 1);

    if (FILTER_CYCLES < FAULT_FILTER_MIN_CLOCKS) begin : g_bad_cycles
        $error("filter count below the minimum spike suppression time");
    end

    // -------------------------------------------------------------
    // output path selection
    // -------------------------------------------------------------
    path_state_t state;
    path_state_t next_state;
    logic [1:0] sel;
    logic [1:0] next_sel;
    logic wait_drop;
    wire logic [1:0] req_src = temp_select_i ? SRC_TEMPERATURE : SRC_ANGLE_TEST;
    // a finished one-shot waits for enable to drop; the finish wins over a clear
    wire logic next_wait_drop = (state == PATH_ONESHOT && value_read_i)
        || (wait_drop && test_enable_i);

    always_comb begin
        next_state = state;
        next_sel = sel;
        case (state)
            PATH_IDLE: begin
                if (test_enable_i && !wait_drop) begin
                    next_sel = req_src;
                    next_state = test_auto_i ? PATH_ONESHOT : PATH_HELD;
                end
            end
            PATH_HELD: begin
                if (!test_enable_i) begin
                    next_state = PATH_IDLE;
                    next_sel = SRC_MAGNETIC;
                end else begin
                    next_sel = req_src;
                end
            end
            PATH_ONESHOT: begin
                if (value_read_i) begin
                    next_state = PATH_IDLE;
                    next_sel = SRC_MAGNETIC;
                end
            end
            default: begin
                next_state = PATH_IDLE;
                next_sel = SRC_MAGNETIC;
            end
        endcase
    end

    // one-shot returns to idle; a still-high enable would restart, so it is
    // treated as a new request only after it has been dropped
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= PATH_IDLE;
            sel <= SRC_MAGNETIC;
            wait_drop <= 1'b0;
        end else begin
            state <= next_state;
            sel <= next_sel;
            wait_drop <= next_wait_drop;
        end
    end

    // shared mux for both substitute sources
    wire logic [SAMPLE_WIDTH-1:0] mux_x = (sel == SRC_TEMPERATURE) ? temp_value_i :
        (sel == SRC_ANGLE_TEST) ? angle_test_x_i : mag_x_i;
    wire logic [SAMPLE_WIDTH-1:0] mux_y = (sel == SRC_ANGLE_TEST) ? angle_test_y_i : mag_y_i;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_x_o <= SAMPLE_RESET;
            out_y_o <= SAMPLE_RESET;
        end else begin
            out_x_o <= mux_x;
            out_y_o <= mux_y;
        end
    end
    assign path_source_o = sel;

    // -------------------------------------------------------------
    // comparator synchronisers and spike filters
    // -------------------------------------------------------------
    wire logic [NCMP-1:0] cmp_raw = {vdd_off_cmp_i, gnd_off_cmp_i, vdd_ov_cmp_i,
        regulator_ov_cmp_i};
    logic [NCMP-1:0] sync1;
    logic [NCMP-1:0] sync2;
    logic [NCMP-1:0] sync3;
    logic [NCMP-1:0] level;
    logic [NCMP-1:0] filtered;
    logic [CW-1:0] cnt [NCMP];

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            level <= '0;
        end else begin
            sync1 <= cmp_raw;
            sync2 <= sync1;
            sync3 <= sync2;
            // each bit follows only once its second and third stages agree
            level <= (sync2 & sync3) | (level & (sync2 | sync3));
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < NCMP; i++) begin
                cnt[i] <= '0;
            end
            filtered <= '0;
        end else begin
            for (int i = 0; i < NCMP; i++) begin
                if (!level[i]) begin
                    cnt[i] <= '0;
                    filtered[i] <= 1'b0;
                end else if (cnt[i] < CW'(FILTER_CYCLES)) begin
                    cnt[i] <= cnt[i] + CW'(1);
                end else begin
                    filtered[i] <= 1'b1;
                end
            end
        end
    end

    // -------------------------------------------------------------
    // status bits for the serial port registers
    // -------------------------------------------------------------
    assign regulator_overvoltage_flag_o = filtered[REGULATOR_COUNT-1:0];
    assign supply_source_flag_o = filtered[NCMP-1:REGULATOR_COUNT];
    assign supply_fault_status_o = filtered[REGULATOR_COUNT + SRC_VDD_OV]
        | filtered[REGULATOR_COUNT + SRC_GND_OFF]
        | filtered[REGULATOR_COUNT + SRC_VDD_OFF];

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    short_spike_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(filtered[0]) |-> cnt[0] == CW'(FILTER_CYCLES))
        else $error("fault flag set before filter time");
    drop_clears_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !level[0] |=> !filtered[0])
        else $error("flag stayed after fault ended");
    shared_status_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        supply_fault_status_o == (|supply_source_flag_o))
        else $error("shared status mismatch");
    gnd_sets_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        filtered[REGULATOR_COUNT + SRC_GND_OFF] |-> supply_fault_status_o)
        else $error("ground fault not reported");
    vdd_off_sets_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        filtered[REGULATOR_COUNT + SRC_VDD_OFF] |-> supply_fault_status_o)
        else $error("disconnect not reported");
    held_stays_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state == PATH_HELD && test_enable_i) |=> sel != SRC_MAGNETIC)
        else $error("held mode left without end");
    oneshot_back_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state == PATH_ONESHOT && value_read_i) |=> sel == SRC_MAGNETIC)
        else $error("auto mode did not return");
    no_restart_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state == PATH_IDLE && wait_drop) |=> state == PATH_IDLE)
        else $error("one-shot restarted without enable drop");
    temp_in_x_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        sel == SRC_TEMPERATURE |=> out_x_o == $past(temp_value_i))
        else $error("temperature not in x slot");
    reg_flag_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        regulator_overvoltage_flag_o == filtered[REGULATOR_COUNT-1:0])
        else $error("regulator flag mismatch");

    held_run_c: cover property (@(posedge ref_clk_i) disable iff (rst_i) state == PATH_HELD);
    oneshot_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        state == PATH_ONESHOT ##1 state == PATH_IDLE);
    temp_c: cover property (@(posedge ref_clk_i) disable iff (rst_i) sel == SRC_TEMPERATURE);
    fault_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(supply_fault_status_o));
endmodule

// *** bench/host_model.sv ***
// host side model: reads one output value over the serial port on request
// assumes requests and pulses are driven at the falling edge of the core clock
module host_model (
    input wire logic clk_i,
    input wire logic start_i,
    input wire logic [3:0] delay_i,
    input wire logic [15:0] out_x_i,
    output logic value_read_o,
    output logic [15:0] read_x_o,
    output logic done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // -------------------------------------------------------------
    // one read per request, after a chosen wait
    // -------------------------------------------------------------
    initial begin
        value_read_o = 1'b0;
        done_o = 1'b0;
        read_x_o = 16'h0000;
        forever begin
            @(negedge clk_i);
            if (start_i && !done_o) begin
                repeat (delay_i) @(negedge clk_i);
                read_x_o = out_x_i; // x output value kept as the read result, whichever source is selected
                value_read_o = 1'b1;
                @(negedge clk_i);
                value_read_o = 1'b0;
                done_o = 1'b1;
            end else if (!start_i) begin
                done_o = 1'b0;
            end
        end
    end
endmodule

// *** bench/testbench.sv ***
// self-checking bench for the supply fault filter and test path
// assumes host_model stands on the serial side; inputs change at falling edges
module testbench;
    import fault_filter_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 0, rst_i = 1, en = 0, auto_m = 0, tsel = 0, start = 0;
    logic [15:0] mx, my, ax, ay, tv, out_x, out_y, read_x;
    logic [1:0] src;
    logic [2:0] regf, supf;
    logic [5:0] cmp = '0;
    logic [3:0] dly = 4'h3;
    logic stat, vread, done;
    wire logic [15:0] flags = {9'h000, stat, supf, regf};
    int err_count = 0, total_checks = 0;
    always #10 ref_clk_i = ~ref_clk_i;
    supply_fault_filter_and_test_path #(.FILTER_CYCLES(256)) i_supply_fault_filter_and_test_path (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .test_enable_i(en), .test_auto_i(auto_m),
        .temp_select_i(tsel), .value_read_i(vread), .mag_x_i(mx), .mag_y_i(my),
        .angle_test_x_i(ax), .angle_test_y_i(ay), .temp_value_i(tv),
        .regulator_ov_cmp_i(cmp[2:0]), .vdd_ov_cmp_i(cmp[3]), .gnd_off_cmp_i(cmp[4]),
        .vdd_off_cmp_i(cmp[5]), .out_x_o(out_x), .out_y_o(out_y), .path_source_o(src),
        .regulator_overvoltage_flag_o(regf), .supply_source_flag_o(supf),
        .supply_fault_status_o(stat));
    host_model i_host_model (.clk_i(ref_clk_i), .start_i(start), .delay_i(dly),
        .out_x_i(out_x), .value_read_o(vread), .read_x_o(read_x), .done_o(done));
    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic summarize();
        if (err_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    function automatic logic [15:0] exp_x(input logic [1:0] s);
        return (s == SRC_TEMPERATURE) ? tv : (s == SRC_ANGLE_TEST) ? ax : mx;
    endfunction
    function automatic logic [15:0] exp_flags(input logic [5:0] c);
        return {9'h000, |c[5:3], c};
    endfunction
    task automatic randomize_inputs();
        mx = 16'($urandom);
        my = 16'($urandom);
        ax = 16'($urandom);
        ay = 16'($urandom);
        tv = 16'($urandom);
    endtask
    task automatic check_path(input logic [1:0] s);
        check("path_source", {14'h0000, src}, {14'h0000, s});
        check("out_x", out_x, exp_x(s));
        check("out_y", out_y, (s == SRC_ANGLE_TEST) ? ay : my);
    endtask
    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial begin
        logic [5:0] one;
        void'($urandom(32'h2099_98a9));
        randomize_inputs();
        cyc(20);
        check("reset_out", out_x | out_y, 16'h0000);
        check("reset_flags", {7'h00, src, stat, supf, regf}, 16'h0000);
        rst_i = 0;
        cyc(2);
        for (int k = 0; k < 3; k++) begin
            randomize_inputs();
            en = 1;
            auto_m = 0;
            tsel = 0;
            cyc(3);
            check_path(SRC_ANGLE_TEST);
            start = 1;
            dly = 4'h3;
            cyc(20);
            check_path(SRC_ANGLE_TEST); // held through a read
            start = 0;
            tsel = 1;
            cyc(3);
            check_path(SRC_TEMPERATURE);
            en = 0;
            cyc(3);
            check_path(SRC_MAGNETIC);
            for (int t = 0; t < 2; t++) begin
                randomize_inputs();
                en = 1;
                auto_m = 1;
                tsel = t[0];
                dly = 4'($urandom_range(15, 3));
                start = 1;
                for (int w = 0; w <= 100 && !done; w++) begin
                    if (w == 100) begin
                        err_count++;
                        summarize();
                    end
                    cyc(1);
                end
                check("one_shot_value", read_x, exp_x(t[0] ? 2'h2 : 2'h1));
                cyc(2);
                check_path(SRC_MAGNETIC); // back after one read
                start = 0;
                cyc(5);
                check_path(SRC_MAGNETIC); // no restart while enable stays
                en = 0;
                cyc(2);
            end
        end
        for (int b = 0; b < 7; b++) begin
            one = (b < 6) ? 6'(1 << b) : 6'($urandom_range(63, 1));
            cmp = one;
            for (int i = 0; i < 200; i++) begin
                cyc(1);
                check("short_spike", {9'h000, stat, supf, regf}, 16'h0000);
            end
            cmp = '0;
            cyc(10);
            cmp = one;
            cyc(250);
            check("early_flags", {9'h000, stat, supf, regf}, 16'h0000);
            cyc(50);
            check("reg_flags", {13'h0000, regf}, {13'h0000, one[2:0]});
            check("fault_flags", flags, exp_flags(one));
            cmp = '0;
            cyc(8);
            check("cleared_flags", {9'h000, stat, supf, regf}, 16'h0000);
        end
        // reset in mid-run with a held request and every fault active
        auto_m = 0;
        tsel = 0;
        en = 1;
        cmp = 6'h3f;
        cyc(300);
        check("all_flags", flags, exp_flags(6'h3f));
        rst_i = 1;
        cyc(2);
        check("reset_flags", {7'h00, src, stat, supf, regf}, 16'h0000);
        check("reset_out", out_x | out_y, 16'h0000);
        rst_i = 0;
        cyc(3);
        check_path(SRC_ANGLE_TEST);
        cyc(270);
        check("refault_flags", flags, exp_flags(6'h3f));
        summarize();
    end
endmodule
